// ### dv/circ_periph_model.sv
/*
 * Model of the external interrupting peripherals: request pins and the
 * data bus answer during an acknowledge cycle.
 * Assumes the bench commands the requests and the answer byte.
 */
`timescale 1ns/100ps
module circ_periph_model (
  input  wire logic       clk_i,
  input  wire logic       ack_cycle_i,
  input  wire logic       nmi_req_i,
  input  wire logic       lvl0_req_i,
  input  wire logic [7:0] resp_i,
  output logic            nmi_n_o,
  output logic            lvl0_n_o,
  output logic [7:0]      bus_o
);
  logic [7:0] junk_r = 8'ha5; // Filler while the bus is not ours.

  ////////////////////////////////////////////////////////////////////
  // Pins are pulled up, so an idle request reads high.
  assign nmi_n_o  = ~nmi_req_i;
  assign lvl0_n_o = ~lvl0_req_i;

  // The filler flips every cycle so a stale byte never looks valid.
  always @(posedge clk_i) begin
    junk_r <= ~junk_r;
  end

  // Drive the instruction or vector byte only inside the acknowledge.
  assign bus_o = ack_cycle_i ? resp_i : junk_r;
endmodule

// ### dv/testbench.sv
/*
 * Self-checking bench of the interrupt response controller.
 * Assumes the controller, its constants header and the peripheral model.
 */
`timescale 1ns/100ps
`include "circ_consts.svh"
module testbench;
  // Strobe positions of the core sequencer vector.
  localparam logic [9:0] OP_DIS  = 10'h001;
  localparam logic [9:0] OP_ENA  = 10'h002;
  localparam logic [9:0] OP_RNMI = 10'h004;
  localparam logic [9:0] OP_RINT = 10'h008;
  localparam logic [9:0] OP_LDPV = 10'h010;
  localparam logic [9:0] OP_MODE = 10'h020;
  localparam logic [9:0] SQ_SPT  = 10'h040;
  localparam logic [9:0] SQ_MCE  = 10'h080;
  localparam logic [9:0] SQ_T3   = 10'h100;
  localparam logic [9:0] SQ_UND  = 10'h200;

  logic        clk_i = 1'h0, rst_i = 1'h1;
  logic        cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [9:0]  ctl = 10'h000; // Core strobes, one bit each.
  logic        b3 = 1'h0, nmi_req = 1'h0, lvl0_req = 1'h0;
  logic [1:0]  im_mode_i = 2'h0, response_mode_o;
  logic [7:0]  resp = 8'h00, bus, ack_opcode_o;
  logic [15:0] vector_o;
  logic        nmi_n, lvl0_n, ack_o, global_irq_enable_o, saved_irq_enable_o;
  logic        dma_master_enable_o, irq_ack_cycle_o, wait_insert_o;
  logic        trap_state_o, no_insert_o, push_pc_o, pop_pc_o, jump_o;
  logic        ack_opcode_vld_o, vec_low_vld_o;
  logic        parity_overflow_flag_o, parity_overflow_we_o;
  int          err_total = 0, tests_run = 0;

  always #50 clk_i = ~clk_i;

  circ_irq_ctrl DUT (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i,
    .dat_o, .ack_o, .nonmaskable_irq_in_n_i(nmi_n),
    .maskable_irq_level0_n_i(lvl0_n), .data_bus_i(bus),
    .sample_pt_i(ctl[6]), .mcycle_end_i(ctl[7]), .t3_rise_i(ctl[8]),
    .undef_fetch_i(ctl[9]), .undef_byte3_i(b3), .exec_di_i(ctl[0]),
    .exec_ei_i(ctl[1]), .exec_return_from_nonmaskable_i(ctl[2]), .exec_return_from_interrupt_i(ctl[3]),
    .exec_ld_a_ir_i(ctl[4]), .exec_im_i(ctl[5]), .im_mode_i,
    .global_irq_enable_o, .saved_irq_enable_o, .dma_master_enable_o,
    .response_mode_o, .irq_ack_cycle_o, .wait_insert_o, .trap_state_o,
    .no_insert_o, .push_pc_o, .pop_pc_o, .jump_o, .vector_o, .ack_opcode_o,
    .ack_opcode_vld_o, .vec_low_vld_o, .parity_overflow_flag_o,
    .parity_overflow_we_o
  );

  circ_periph_model PERIPH (
    .clk_i, .ack_cycle_i(irq_ack_cycle_o), .nmi_req_i(nmi_req),
    .lvl0_req_i(lvl0_req), .resp_i(resp), .nmi_n_o(nmi_n),
    .lvl0_n_o(lvl0_n), .bus_o(bus)
  );

  ////////////////////////////////////////////////////////////////////
  // Compare with case inequality so an unknown never matches.
  task automatic chk(input string nm, input logic [15:0] ex, got);
    tests_run++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One classic bus cycle; the answer latency is not assumed.
  // Ack and read data are taken at the rising edge where ack is seen high.
  task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i} <= {2'h3, w};
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'h1);
    q = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'h0;
    @(posedge clk_i);
    chk("ack drop", 1'h0, ack_o);
  endtask

  // A one-cycle strobe, then look at the settled outputs.
  task automatic pulse(input logic [9:0] v);
    @(posedge clk_i);
    ctl <= v;
    @(posedge clk_i);
    ctl <= 10'h000;
    @(negedge clk_i);
  endtask

  // Level request; the pin filter needs a few clocks to see it.
  task automatic set_lvl0(input logic v);
    @(posedge clk_i);
    lvl0_req <= v;
    repeat (5) @(posedge clk_i);
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_i);
    im_mode_i <= m;
    pulse(OP_MODE);
    chk("mode", m, response_mode_o);
  endtask

  // Sampling point, then the end of the machine cycle.
  task automatic ack_seq;
    pulse(SQ_SPT);
    chk("push early", 1'h0, push_pc_o);
    pulse(SQ_MCE);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] q;
    @(negedge clk_i);
    chk("global", 1'h0, global_irq_enable_o);
    chk("saved", 1'h0, saved_irq_enable_o);
    chk("mode", 2'h0, response_mode_o);
    wb(1'h0, `CIRC_ADR_ITC, 8'h00, q);
    chk("ctl reg", 8'h01, q);
    wb(1'h0, 8'hfc, 8'h00, q);
    chk("unmapped", 8'h00, q);
  endtask

  task automatic t_flags;
    pulse(OP_ENA);
    chk("global", 1'h1, global_irq_enable_o);
    chk("saved", 1'h1, saved_irq_enable_o);
    pulse(OP_LDPV);
    chk("pv", 1'h1, parity_overflow_flag_o);
    chk("pv write", 1'h1, parity_overflow_we_o);
    chk("global", 1'h1, global_irq_enable_o);
    pulse(OP_DIS);
    chk("global", 1'h0, global_irq_enable_o);
    chk("saved", 1'h0, saved_irq_enable_o);
    pulse(OP_LDPV);
    chk("pv", 1'h0, parity_overflow_flag_o);
  endtask

  // Low request with the global flag clear, then with the pin enable clear.
  task automatic t_masked;
    logic [7:0] q;
    set_lvl0(1'h1);
    ack_seq();
    chk("push", 1'h0, push_pc_o);
    wb(1'h1, `CIRC_ADR_ITC, 8'h00, q);
    pulse(OP_ENA);
    ack_seq();
    chk("ack cycle", 1'h0, irq_ack_cycle_o);
    set_lvl0(1'h0);
    wb(1'h1, `CIRC_ADR_ITC, 8'h01, q);
  endtask

  task automatic t_mode1;
    set_mode(2'h1);
    set_lvl0(1'h1);
    ack_seq();
    chk("push", 1'h1, push_pc_o);
    chk("jump", 1'h1, jump_o);
    chk("vector", 16'h0038, vector_o);
    chk("global", 1'h0, global_irq_enable_o);
    chk("saved", 1'h0, saved_irq_enable_o);
    set_lvl0(1'h0);
    pulse(OP_ENA);
    pulse(OP_RINT);
    chk("pop", 1'h1, pop_pc_o);
    chk("global", 1'h1, global_irq_enable_o);
    chk("saved", 1'h1, saved_irq_enable_o);
  endtask

  // Both pins low at once; the edge is gone before sampling.
  task automatic t_nmi;
    logic [7:0] q;
    wb(1'h1, `CIRC_ADR_DMA, 8'h01, q);
    chk("dma enable", 1'h1, dma_master_enable_o);
    @(posedge clk_i);
    nmi_req <= 1'h1;
    set_lvl0(1'h1);
    nmi_req <= 1'h0;
    wb(1'h0, `CIRC_ADR_STAT, 8'h00, q);
    chk("status", 8'h17, q);
    ack_seq();
    chk("vector", 16'h0066, vector_o);
    chk("push", 1'h1, push_pc_o);
    chk("dma enable", 1'h0, dma_master_enable_o);
    chk("saved", 1'h1, saved_irq_enable_o);
    chk("global", 1'h0, global_irq_enable_o);
    set_lvl0(1'h0);
    pulse(OP_RNMI);
    chk("pop", 1'h1, pop_pc_o);
    chk("global", 1'h1, global_irq_enable_o);
    chk("saved", 1'h1, saved_irq_enable_o);
    pulse(OP_DIS);
  endtask

  // Trap entry, the guard cycle, then software clear of the flag.
  task automatic t_trap(input logic b3v, input logic f);
    logic [7:0] q;
    @(posedge clk_i);
    b3 <= b3v;
    pulse(SQ_UND);
    chk("trap state", 1'h1, trap_state_o);
    chk("push", 1'h1, push_pc_o);
    chk("vector", 16'h0000, vector_o);
    chk("global", f, global_irq_enable_o);
    chk("saved", f, saved_irq_enable_o);
    @(negedge clk_i);
    chk("no insert", 1'h1, no_insert_o);
    wb(1'h0, `CIRC_ADR_ITC, 8'h00, q);
    chk("ctl reg", {1'h1, b3v, 6'h01}, q);
    wb(1'h1, `CIRC_ADR_ITC, 8'h01, q);
    wb(1'h1, `CIRC_ADR_ITC, 8'h81, q);
    wb(1'h0, `CIRC_ADR_ITC, 8'h00, q);
    chk("ctl reg", {1'h0, b3v, 6'h01}, q);
  endtask

  task automatic t_mode0;
    set_mode(2'h0);
    @(posedge clk_i);
    resp <= 8'hff;
    pulse(OP_ENA);
    set_lvl0(1'h1);
    ack_seq();
    chk("ack cycle", 1'h1, irq_ack_cycle_o);
    chk("push", 1'h0, push_pc_o);
    chk("global", 1'h0, global_irq_enable_o);
    set_lvl0(1'h0);
    pulse(SQ_T3);
    chk("opcode valid", 1'h1, ack_opcode_vld_o);
    chk("opcode", 8'hff, ack_opcode_o);
    t_trap(1'h0, 1'h0);
  endtask

  task automatic t_mode2;
    set_mode(2'h2);
    @(posedge clk_i);
    resp <= 8'h5a;
    set_lvl0(1'h1);
    ack_seq();
    chk("wait", 1'h1, wait_insert_o);
    @(negedge clk_i);
    chk("wait", 1'h1, wait_insert_o);
    @(negedge clk_i);
    chk("wait", 1'h0, wait_insert_o);
    set_lvl0(1'h0);
    pulse(SQ_T3);
    chk("low vector", 1'h1, vec_low_vld_o);
    chk("vector", 16'h005a, vector_o);
    // Code 3 names no mode, so the mode must stay as it was.
    @(posedge clk_i);
    im_mode_i <= 2'h3;
    pulse(OP_MODE);
    chk("mode", 2'h2, response_mode_o);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The whole run takes well under a thousand cycles.
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_flags();
    t_masked();
    t_mode1();
    t_nmi();
    t_mode0();
    pulse(OP_ENA);
    t_trap(1'h1, 1'h1);
    t_mode2();
    give_verdict();
  end
endmodule

// ### logic/circ_consts.svh
/*
 * Constants of the interrupt response controller: register offsets, field
 * positions, reset values, restart addresses and cycle counts.
 * Assumes it is included by bare name from the controller's design files.
 */
// Operation
// - Global enable low blocks every maskable request.
// - Disable clears both flags, enable sets both.
// - Nonmaskable entry saves global flag, then clears.
// - Nonmaskable return pops PC, restores global flag.
// - Maskable entry clears both; trap, return keep.
// - Accumulator load copies global flag into parity.
// - Undefined opcode fetch always raises the trap.
// - Trap sets flag, pushes PC, jumps zero.
// - Byte position selects PC minus one or two.
// - No bus insertion right after trap state.
// - Nonmaskable falling edge latched until sampled.
// - Latched request sampled late; acknowledge next cycle.
// - Nonmaskable acknowledge suspends DMA, pushes, jumps 0066.
// - Nonmaskable first, level zero second priority.
// - Level zero sampled low at sampling point.
// - Level zero masked by either enable low.
// - Reset: level zero enable one, global zero.
// - Mode chosen by instruction; reset selects zero.
// - Mode zero executes bus opcode, no push.
// - Invalid mode zero opcode takes the trap.
// - Mode one pushes, clears flags, jumps 0038.
// - Software clears trap flag, never sets it.
// - Reset clears global and level one, two enables.
// - Mode two captures low vector at T3.
// - Two wait states in external vector fetch.
`ifndef CIRC_CONSTS_SVH
`define CIRC_CONSTS_SVH

// Register byte offsets on the bus.
`define CIRC_ADR_ITC      8'h00
`define CIRC_ADR_STAT     8'h04
`define CIRC_ADR_DMA      8'h08

// Trap and control register fields and reset value.
`define CIRC_ITC_TRAP     7
`define CIRC_ITC_UFO      6
`define CIRC_ITC_RST      3'h1

// Status register fields.
`define CIRC_ST_GLOBAL_IRQ_ENABLE      0
`define CIRC_ST_SAVED_IRQ_ENABLE      1
`define CIRC_ST_MODE      2
`define CIRC_ST_NMI       4

// DMA control field and reset value.
`define CIRC_DMA_DME      0
`define CIRC_DME_RST      1'h0

// Restart addresses.
`define CIRC_VEC_TRAP     16'h0000
`define CIRC_VEC_NMI      16'h0066
`define CIRC_VEC_MODE1    16'h0038

// Response modes and reset mode.
`define CIRC_MODE0        2'h0
`define CIRC_MODE1        2'h1
`define CIRC_MODE2        2'h2

// Wait states inserted in an external vector fetch.
`define CIRC_VEC_WAITS    2'h2

`endif

// ### logic/circ_irq_ctrl.sv
/*
 * Interrupt response controller of an 8-bit processor core: enable flags,
 * undefined-opcode trap, nonmaskable entry and return, level 0 maskable
 * request in modes 0, 1 and 2, and a classic Wishbone register slave.
 * Assumes the core sequencer gives one-cycle strobes on the same clock for
 * the sampling point, machine cycle end, T3 rising edge and executed
 * instructions, and acts on the push, pop and jump pulses it receives.
 */
`timescale 1ns/100ps
`include "circ_consts.svh"
module circ_irq_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        nonmaskable_irq_in_n_i,
  input  wire logic        maskable_irq_level0_n_i,
  input  wire logic [7:0]  data_bus_i,
  input  wire logic        sample_pt_i,
  input  wire logic        mcycle_end_i,
  input  wire logic        t3_rise_i,
  input  wire logic        undef_fetch_i,
  input  wire logic        undef_byte3_i,
  input  wire logic        exec_di_i,
  input  wire logic        exec_ei_i,
  input  wire logic        exec_return_from_nonmaskable_i,
  input  wire logic        exec_return_from_interrupt_i,
  input  wire logic        exec_ld_a_ir_i,
  input  wire logic        exec_im_i,
  input  wire logic [1:0]  im_mode_i,
  output logic             global_irq_enable_o,
  output logic             saved_irq_enable_o,
  output logic             dma_master_enable_o,
  output logic [1:0]       response_mode_o,
  output logic             irq_ack_cycle_o,
  output logic             wait_insert_o,
  output logic             trap_state_o,
  output logic             no_insert_o,
  output logic             push_pc_o,
  output logic             pop_pc_o,
  output logic             jump_o,
  output logic [15:0]      vector_o,
  output logic [7:0]       ack_opcode_o,
  output logic             ack_opcode_vld_o,
  output logic             vec_low_vld_o,
  output logic             parity_overflow_flag_o,
  output logic             parity_overflow_we_o
);

  circ_pkg::circ_state_t s_r;    // Registered state.
  circ_pkg::circ_state_t s_nxt;  // Next state.
  logic                  nmi_fall;  // Filtered falling edge of the pin.
  logic                  maskable_irq_level0_lvl;  // Filtered level of level 0 pin.
  logic                  bus_req;   // Access in progress.
  logic                  bus_wr;    // Write taking effect this edge.
  logic                  start;     // Acknowledge starts this cycle.
  logic                  start_nmi; // Nonmaskable acknowledge starts.
  logic                  start_int; // Level 0 acknowledge starts.
  logic                  maskable_irq_level0_ok;   // Level 0 request unmasked.

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  circ_pin_sync u_nmi_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_n_i (nonmaskable_irq_in_n_i),
    .lvl_o   (),
    .fall_o  (nmi_fall)
  );

  circ_pin_sync u_maskable_irq_level0_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_n_i (maskable_irq_level0_n_i),
    .lvl_o   (maskable_irq_level0_lvl),
    .fall_o  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode of bus strobes and acknowledge start.

  // A write lands at the edge where the master sees ack, while held.
  assign bus_req   = cyc_i & stb_i;
  assign bus_wr    = bus_req & we_i & s_r.wb_ack & sel_i[0];
  // Both the global flag and the level 0 enable gate the request.
  assign maskable_irq_level0_ok   = s_r.global_irq_enable & s_r.ite[0];
  // A trap preempts an acknowledge starting in the same cycle.
  assign start     = mcycle_end_i & (s_r.seq == circ_pkg::SEQ_IDLE) &
                     (s_r.pend != circ_pkg::PEND_NONE) & ~undef_fetch_i;
  assign start_nmi = start & (s_r.pend == circ_pkg::PEND_NMI);
  assign start_int = start & (s_r.pend == circ_pkg::PEND_MASKABLE_IRQ_LEVEL0);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: every flag, sequence and bus register in one place.
  always_comb begin
    s_nxt         = s_r;
    s_nxt.push    = 1'b0;
    s_nxt.pop     = 1'b0;
    s_nxt.jump    = 1'b0;
    s_nxt.opc_vld = 1'b0;
    s_nxt.vlo_vld = 1'b0;
    s_nxt.pv_we   = 1'b0;

    // The edge is held until the sampling point consumes it.
    if (sample_pt_i && s_r.seq == circ_pkg::SEQ_IDLE &&
        s_r.pend == circ_pkg::PEND_NONE) begin
      if (s_r.nmi_lat) begin
        s_nxt.pend    = circ_pkg::PEND_NMI;
        s_nxt.nmi_lat = 1'b0;
      end else if (!maskable_irq_level0_lvl && maskable_irq_level0_ok) begin
        s_nxt.pend = circ_pkg::PEND_MASKABLE_IRQ_LEVEL0;  // Low level accepted.
      end
    end
    // A new edge in the sampling cycle is kept, not lost.
    if (nmi_fall) begin
      s_nxt.nmi_lat = 1'b1;
    end

    // Instructions that touch the flags; an acknowledge overrides below.
    if (exec_di_i) begin
      s_nxt.global_irq_enable = 1'b0;
      s_nxt.saved_irq_enable = 1'b0;
    end else if (exec_ei_i) begin
      s_nxt.global_irq_enable = 1'b1;
      s_nxt.saved_irq_enable = 1'b1;
    end else if (exec_return_from_nonmaskable_i) begin
      s_nxt.global_irq_enable = s_r.saved_irq_enable;  // Saved flag stays as it is.
    end
    // Both returns pop; the plain return leaves the flags.
    if (exec_return_from_nonmaskable_i || exec_return_from_interrupt_i) begin
      s_nxt.pop = 1'b1;
    end
    if (exec_ld_a_ir_i) begin
      s_nxt.pv    = s_r.global_irq_enable;
      s_nxt.pv_we = 1'b1;
    end
    // Code 3 is no mode and is ignored.
    if (exec_im_i && im_mode_i != 2'h3) begin
      s_nxt.mode = im_mode_i;
    end

    // Acknowledge sequencer.
    unique case (s_r.seq)
      circ_pkg::SEQ_IDLE: begin
        if (start_nmi) begin
          s_nxt.dma_master_enable  = 1'b0;       // Suspend the DMA unit.
          s_nxt.saved_irq_enable = s_r.global_irq_enable;
          s_nxt.global_irq_enable = 1'b0;
          s_nxt.push = 1'b1;
          s_nxt.jump = 1'b1;
          s_nxt.vec  = `CIRC_VEC_NMI;
          s_nxt.pend = circ_pkg::PEND_NONE;
        end else if (start_int) begin
          s_nxt.global_irq_enable = 1'b0;
          s_nxt.saved_irq_enable = 1'b0;
          s_nxt.pend = circ_pkg::PEND_NONE;
          if (s_r.mode == `CIRC_MODE1) begin
            s_nxt.push = 1'b1;
            s_nxt.jump = 1'b1;
            s_nxt.vec  = `CIRC_VEC_MODE1;
          end else begin
            // Modes 0 and 2 run a bus acknowledge cycle.
            s_nxt.seq  = circ_pkg::SEQ_ACK;
            s_nxt.wcnt = (s_r.mode == `CIRC_MODE2) ? `CIRC_VEC_WAITS : 2'h0;
          end
        end
      end
      circ_pkg::SEQ_ACK: begin
        if (s_r.wcnt != 2'h0) begin
          s_nxt.wcnt = s_r.wcnt - 2'h1;
        end else if (t3_rise_i) begin
          s_nxt.seq = circ_pkg::SEQ_IDLE;
          if (s_r.mode == `CIRC_MODE2) begin
            s_nxt.vec     = {8'h00, data_bus_i};
            s_nxt.vlo_vld = 1'b1;
            s_nxt.push    = 1'b1;
          end else begin
            // The peripheral drives the opcode; no push here.
            s_nxt.opc     = data_bus_i;
            s_nxt.opc_vld = 1'b1;
          end
        end
      end
      circ_pkg::SEQ_TTP: begin
        s_nxt.seq = circ_pkg::SEQ_GUARD;
      end
      circ_pkg::SEQ_GUARD: begin
        s_nxt.seq = circ_pkg::SEQ_IDLE;
      end
    endcase

    // Software clears the trap flag only; bit value 1 is ignored.
    if (bus_wr && adr_i == `CIRC_ADR_ITC) begin
      if (!dat_i[`CIRC_ITC_TRAP]) begin
        s_nxt.trap = 1'b0;
      end
      s_nxt.ite = dat_i[2:0];
    end
    if (bus_wr && adr_i == `CIRC_ADR_DMA) begin
      s_nxt.dma_master_enable = dat_i[`CIRC_DMA_DME];
    end
    // Suspension by the nonmaskable entry beats a software write.
    if (start_nmi) begin
      s_nxt.dma_master_enable = 1'b0;
    end

    // Undefined fetch, also in a mode 0 acknowledge, traps at once.
    // It overrides the sequencer and the trap flag above and keeps both enable flags.
    if (undef_fetch_i) begin
      s_nxt.trap = 1'b1;           // Set wins over a clear.
      s_nxt.trap_byte_position  = undef_byte3_i;
      s_nxt.push = 1'b1;
      s_nxt.jump = 1'b1;
      s_nxt.vec  = `CIRC_VEC_TRAP;
      s_nxt.seq  = circ_pkg::SEQ_TTP;
      s_nxt.opc_vld = 1'b0;
      s_nxt.vlo_vld = 1'b0;
      s_nxt.global_irq_enable = s_r.global_irq_enable;
      s_nxt.saved_irq_enable = s_r.saved_irq_enable;
    end

    // Bus slave: ack one cycle after the request, dropped the next.
    s_nxt.wb_ack = bus_req & ~s_r.wb_ack;
    if (bus_req && !s_r.wb_ack) begin
      unique case (adr_i)
        `CIRC_ADR_ITC:  s_nxt.wb_dat = {s_r.trap, s_r.trap_byte_position, 3'h0, s_r.ite};
        `CIRC_ADR_STAT: s_nxt.wb_dat = {3'h0, s_r.nmi_lat, s_r.mode,
                                        s_r.saved_irq_enable, s_r.global_irq_enable};
        `CIRC_ADR_DMA:  s_nxt.wb_dat = {7'h00, s_r.dma_master_enable};
        default:        s_nxt.wb_dat = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset gives mode 0, both flags off, level 0 enabled.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r      <= '0;
      s_r.ite  <= `CIRC_ITC_RST;
      s_r.mode <= `CIRC_MODE0;
      s_r.dma_master_enable  <= `CIRC_DME_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign dat_o                  = {24'h000000, s_r.wb_dat};
  assign ack_o                  = s_r.wb_ack;
  assign global_irq_enable_o    = s_r.global_irq_enable;
  assign saved_irq_enable_o     = s_r.saved_irq_enable;
  assign dma_master_enable_o    = s_r.dma_master_enable;
  assign response_mode_o        = s_r.mode;
  assign irq_ack_cycle_o        = (s_r.seq == circ_pkg::SEQ_ACK);
  assign wait_insert_o          = irq_ack_cycle_o & (s_r.wcnt != 2'h0);
  assign trap_state_o           = (s_r.seq == circ_pkg::SEQ_TTP);
  assign no_insert_o            = (s_r.seq == circ_pkg::SEQ_GUARD);
  assign push_pc_o              = s_r.push;
  assign pop_pc_o               = s_r.pop;
  assign jump_o                 = s_r.jump;
  assign vector_o               = s_r.vec;
  assign ack_opcode_o           = s_r.opc;
  assign ack_opcode_vld_o       = s_r.opc_vld;
  assign vec_low_vld_o          = s_r.vlo_vld;
  assign parity_overflow_flag_o = s_r.pv;
  assign parity_overflow_we_o   = s_r.pv_we;

  ////////////////////////////////////////////////////////////////////////////
  // Checks of the documented behaviour.

  a_di_clears_both: assert property (
    @(posedge clk_i) disable iff (rst_i)
    exec_di_i && !start && !undef_fetch_i |=> !s_r.global_irq_enable && !s_r.saved_irq_enable)
    else $error("disable did not clear both flags");

  a_ei_sets_both: assert property (
    @(posedge clk_i) disable iff (rst_i)
    exec_ei_i && !exec_di_i && !start && !undef_fetch_i
    |=> s_r.global_irq_enable && s_r.saved_irq_enable)
    else $error("enable did not set both flags");

  a_nmi_entry_seq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start_nmi |=> s_r.saved_irq_enable == $past(s_r.global_irq_enable) && !s_r.global_irq_enable && !s_r.dma_master_enable &&
                  s_r.push && s_r.vec == 16'h0066)
    else $error("nonmaskable entry wrong");

  a_return_from_nonmaskable_restores: assert property (
    @(posedge clk_i) disable iff (rst_i)
    exec_return_from_nonmaskable_i && !exec_di_i && !exec_ei_i && !start && !undef_fetch_i
    |=> s_r.pop && s_r.global_irq_enable == $past(s_r.saved_irq_enable) && $stable(s_r.saved_irq_enable))
    else $error("return did not restore the flag");

  a_int_clears_both: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start_int |=> !s_r.global_irq_enable && !s_r.saved_irq_enable)
    else $error("maskable entry kept a flag");

  a_trap_entry_seq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    undef_fetch_i |=> s_r.trap && s_r.jump && s_r.vec == 16'h0000 &&
                      $stable(s_r.global_irq_enable) && trap_state_o ##1 no_insert_o)
    else $error("trap sequence wrong");

  a_masked_no_pend: assert property (
    @(posedge clk_i) disable iff (rst_i)
    sample_pt_i && !s_r.nmi_lat && !(s_r.global_irq_enable && s_r.ite[0]) &&
    s_r.pend == circ_pkg::PEND_NONE |=> s_r.pend != circ_pkg::PEND_MASKABLE_IRQ_LEVEL0)
    else $error("masked request accepted");

  a_pv_copy_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    exec_ld_a_ir_i |=> s_r.pv_we && s_r.pv == $past(s_r.global_irq_enable))
    else $error("parity flag not loaded");

  a_mode2_two_waits: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start_int && s_r.mode == 2'h2 |=> wait_insert_o[*2] ##1 !wait_insert_o)
    else $error("wait states wrong");

  a_trap_no_swset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    bus_wr && adr_i == 8'h00 && !s_r.trap && !undef_fetch_i |=> !s_r.trap)
    else $error("software set the trap flag");

endmodule

// ### logic/circ_pin_sync.sv
/*
 * Three-flop pin synchroniser with agreement filter and falling-edge pulse.
 * Assumes an asynchronous, idle-high, active-low pin.
 */
`timescale 1ns/100ps
module circ_pin_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_n_i,
  output logic      lvl_o,
  output logic      fall_o
);

  circ_pkg::circ_sync_t s_r;  // Registered state.
  circ_pkg::circ_sync_t s_nxt;  // Next state.

  ////////////////////////////////////////////////////////////////////////////
  // The first flop feeds only the second, so metastability cannot spread.
  // The level moves only when the second and third flops agree.
  always_comb begin
    s_nxt      = s_r;
    s_nxt.ff   = {s_r.ff[1:0], pin_n_i};
    s_nxt.fall = 1'b0;
    if (s_r.ff[1] == s_r.ff[2]) begin
      s_nxt.lvl  = s_r.ff[2];
      s_nxt.fall = s_r.lvl & ~s_r.ff[2];  // Edge seen once.
    end
  end

  // Pins idle high, so reset assumes the released level.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '{ff: 3'h7, lvl: 1'b1, fall: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lvl_o  = s_r.lvl;
  assign fall_o = s_r.fall;

endmodule

// ### logic/circ_pkg.sv
/*
 * Types of the interrupt response controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package circ_pkg;

  // Acknowledge sequencer states.
  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'h0,
    SEQ_ACK   = 2'h1,
    SEQ_TTP   = 2'h2,
    SEQ_GUARD = 2'h3
  } circ_seq_t;

  // Request chosen at the sampling point.
  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_NMI  = 2'h1,
    PEND_MASKABLE_IRQ_LEVEL0 = 2'h2
  } circ_pend_t;

  // Pin synchroniser state.
  typedef struct packed {
    logic [2:0] ff;
    logic       lvl;
    logic       fall;
  } circ_sync_t;

  // Controller state.
  typedef struct packed {
    circ_seq_t  seq;
    circ_pend_t pend;
    logic       global_irq_enable;
    logic       saved_irq_enable;
    logic [1:0] mode;
    logic [2:0] ite;
    logic       trap;
    logic       trap_byte_position;
    logic       dma_master_enable;
    logic       nmi_lat;
    logic [1:0] wcnt;
    logic [15:0] vec;
    logic [7:0] opc;
    logic       opc_vld;
    logic       vlo_vld;
    logic       push;
    logic       pop;
    logic       jump;
    logic       pv;
    logic       pv_we;
    logic       wb_ack;
    logic [7:0] wb_dat;
  } circ_state_t;

endpackage
